// ### hdl/sipr_pkg.sv
// Package for the indirect data, link interrupt and tag priority register slice.
// Assumes an 8-bit register port with byte offsets, on one clock with synchronous reset.
package sipr_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_IND_BYTE6 = 8'h72;
  localparam logic [7:0] ADDR_IND_BYTE5 = 8'h73;
  localparam logic [7:0] ADDR_IND_BYTE4 = 8'h74;
  localparam logic [7:0] ADDR_IND_BYTE3 = 8'h75;
  localparam logic [7:0] ADDR_IND_BYTE2 = 8'h76;
  localparam logic [7:0] ADDR_IND_BYTE1 = 8'h77;
  localparam logic [7:0] ADDR_IND_BYTE0 = 8'h78;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h7c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h7d;
  localparam logic [7:0] ADDR_PRIO_LOW = 8'h80;
  localparam logic [7:0] ADDR_PRIO_HIGH = 8'h81;

  // ==========================================================================
  // Field layout and reset values
  localparam int IND_BYTES = 7;
  localparam int PORT_LO = 1;
  localparam int PORT_HI = 2;
  localparam logic [7:0] IRQ_BITS = 8'h06;
  localparam logic [7:0] IND_RESET = 8'h00;
  localparam logic [7:0] PRIO_LOW_RESET = 8'h50;
  localparam logic [7:0] PRIO_HIGH_RESET = 8'hfa;

  // ==========================================================================
  // Bus and lookup carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sipr_req_t;

  typedef struct packed {
    logic [2:0] tag;
  } sipr_lookup_t;

endpackage

// ### hdl/sipr_regs.sv
// Register slice: indirect data bytes, link change interrupt status and mask,
// and the 802.1p tag to internal priority mapping.
// Assumes requests arrive synchronous to clk; reads answer the cycle after rd.
`timescale 1ns/1ps

// Contract
// - Indirect data byte6 (bits 55-48) and byte5 at 0x73, read/write, reset zero.
// - Byte4 at 0x74 and byte3 at 0x75 hold bits 39-24, reset zero.
// - Bytes at 0x76, 0x77, 0x78 hold bits 23-0, read/write, reset zero.
// - Port 2 link change sets status bit 2; one means pending.
// - Port 1 link change sets status bit 1; one means pending.
// - Writing one clears a status bit; writing zero leaves it unchanged.
// - Mask at 0x7D bits 2 and 1 mask ports; reset zero.
// - Tags 0 and 1 use bits 1-0 and 3-2 at 0x80, reset 0.
// - Tags 2 and 3 use bits 5-4 and 7-6 at 0x80, reset 1.
// - Tag 7 uses bits 7-6 at 0x81, reset 3.
// - Tags 6, 5, 4 use 0x81 bits 5-4, 3-2, 1-0; reset 3, 2, 2.
module sipr_regs
(
  input wire logic clk,
  input wire logic rst,
  input sipr_pkg::sipr_req_t req,
  output logic [7:0] rdata,
  input wire logic [2:1] link_change,
  input sipr_pkg::sipr_lookup_t lookup,
  output logic [1:0] frame_prio,
  output logic [55:0] ind_data,
  output logic irq
);
  import sipr_pkg::*;

  logic [7:0] ind_ff [IND_BYTES];
  logic [7:0] irq_status_ff;
  logic [7:0] irq_mask_ff;
  logic [7:0] prio_low_ff;
  logic [7:0] prio_high_ff;
  logic [7:0] rdata_ff;
  logic [1:0] frame_prio_ff;
  logic [7:0] nxt_irq_status;
  logic [7:0] nxt_rdata;
  logic [15:0] prio_map;
  logic [1:0] prio_for_tag_zero;
  logic [1:0] prio_for_tag_one;
  logic [1:0] prio_for_tag_two;
  logic [1:0] prio_for_tag_three;
  logic [1:0] prio_for_tag_four;
  logic [1:0] prio_for_tag_five;
  logic [1:0] prio_for_tag_six;
  logic [1:0] prio_for_tag_seven;
  logic wr_status;
  logic wr_mask;
  logic wr_low;
  logic wr_high;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;

  // ==========================================================================
  // Address decode.
  assign wr_status = req.wr && (req.addr == ADDR_IRQ_STATUS);
  assign wr_mask = req.wr && (req.addr == ADDR_IRQ_MASK);
  assign wr_low = req.wr && (req.addr == ADDR_PRIO_LOW);
  assign wr_high = req.wr && (req.addr == ADDR_PRIO_HIGH);

  // ==========================================================================
  // Indirect data holding bytes; byte index 0 is bits 7-0 at the highest offset.
  genvar gi;
  generate
    for (gi = 0; gi < IND_BYTES; gi++)
    begin : g_ind
      logic wr_byte;
      assign wr_byte = req.wr && (req.addr == ADDR_IND_BYTE0 - 8'(gi));
      // Plain holding byte, cleared at reset.
      always_ff @(posedge clk)
      begin
        if (rst)
          ind_ff[gi] <= IND_RESET;
        else if (wr_byte)
          ind_ff[gi] <= req.wdata;
      end
      assign ind_data[8*gi +: 8] = ind_ff[gi];
    end
  endgenerate

  // ==========================================================================
  // Status: events set, a written one clears. A set in the clear cycle wins,
  // so a link change that races software is never lost.
  assign set_bits = {5'h00, link_change, 1'b0} & IRQ_BITS;
  assign clr_bits = wr_status ? (req.wdata & IRQ_BITS) : 8'h00;
  assign nxt_irq_status = ((irq_status_ff & ~clr_bits) | set_bits) & IRQ_BITS;

  // Status and mask registers; reserved bits never store.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_status_ff <= 8'h00;
      irq_mask_ff <= 8'h00;
    end
    else
    begin
      irq_status_ff <= nxt_irq_status;
      if (wr_mask)
        irq_mask_ff <= req.wdata & IRQ_BITS;
    end
  end

  // Interrupt is combinational so it drops the cycle after the clear.
  assign irq = |(irq_status_ff & ~irq_mask_ff);

  // ==========================================================================
  // Priority map registers.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prio_low_ff <= PRIO_LOW_RESET;
      prio_high_ff <= PRIO_HIGH_RESET;
    end
    else
    begin
      if (wr_low)
        prio_low_ff <= req.wdata;
      if (wr_high)
        prio_high_ff <= req.wdata;
    end
  end

  assign prio_for_tag_zero = prio_low_ff[1:0];
  assign prio_for_tag_one = prio_low_ff[3:2];
  assign prio_for_tag_two = prio_low_ff[5:4];
  assign prio_for_tag_three = prio_low_ff[7:6];
  assign prio_for_tag_four = prio_high_ff[1:0];
  assign prio_for_tag_five = prio_high_ff[3:2];
  assign prio_for_tag_six = prio_high_ff[5:4];
  assign prio_for_tag_seven = prio_high_ff[7:6];
  // The lookup table is built from the named fields, so each field has a real reader.
  assign prio_map = {prio_for_tag_seven, prio_for_tag_six, prio_for_tag_five, prio_for_tag_four,
    prio_for_tag_three, prio_for_tag_two, prio_for_tag_one, prio_for_tag_zero};

  // Lookup result is registered: one cycle from tag to priority.
  always_ff @(posedge clk)
  begin
    if (rst)
      frame_prio_ff <= 2'h0;
    else
      frame_prio_ff <= prio_map[2*lookup.tag +: 2];
  end
  assign frame_prio = frame_prio_ff;

  // ==========================================================================
  // Read mux; unmapped offsets read zero.
  always_comb
  begin
    nxt_rdata = 8'h00;
    unique case (req.addr)
      ADDR_IND_BYTE6: nxt_rdata = ind_ff[6];
      ADDR_IND_BYTE5: nxt_rdata = ind_ff[5];
      ADDR_IND_BYTE4: nxt_rdata = ind_ff[4];
      ADDR_IND_BYTE3: nxt_rdata = ind_ff[3];
      ADDR_IND_BYTE2: nxt_rdata = ind_ff[2];
      ADDR_IND_BYTE1: nxt_rdata = ind_ff[1];
      ADDR_IND_BYTE0: nxt_rdata = ind_ff[0];
      ADDR_IRQ_STATUS: nxt_rdata = irq_status_ff;
      ADDR_IRQ_MASK: nxt_rdata = irq_mask_ff;
      ADDR_PRIO_LOW: nxt_rdata = prio_low_ff;
      ADDR_PRIO_HIGH: nxt_rdata = prio_high_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data is a flop, valid the cycle after rd.
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_ff <= 8'h00;
    else if (req.rd)
      rdata_ff <= nxt_rdata;
  end
  assign rdata = rdata_ff;

  // ==========================================================================
  // Checks.
  property p_set_wins;
    @(posedge clk) disable iff (rst)
      (link_change[2] && wr_status && req.wdata[2]) |=> irq_status_ff[2];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Port 2 event lost on clear.");

  property p_port1_set;
    @(posedge clk) disable iff (rst)
      link_change[1] |=> irq_status_ff[1];
  endproperty
  a_port1_set: assert property (p_port1_set) else $error("Port 1 event not latched.");

  property p_w1c;
    @(posedge clk) disable iff (rst)
      (wr_status && req.wdata[1] && !link_change[1]) |=> !irq_status_ff[1];
  endproperty
  a_w1c: assert property (p_w1c) else $error("Write one did not clear.");

  property p_w0_keeps;
    @(posedge clk) disable iff (rst)
      (wr_status && !req.wdata[2] && irq_status_ff[2]) |=> irq_status_ff[2];
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("Write zero cleared a bit.");

  property p_mask_wr;
    @(posedge clk) disable iff (rst)
      wr_mask |=> irq_mask_ff == ($past(req.wdata) & IRQ_BITS);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("Mask write wrong.");

  property p_reserved;
    @(posedge clk) disable iff (rst)
      ((irq_status_ff | irq_mask_ff) & ~IRQ_BITS) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bit set.");

  property p_irq;
    @(posedge clk) disable iff (rst)
      (irq_status_ff[1] && !irq_mask_ff[1]) || (irq_status_ff[2] && !irq_mask_ff[2])
        ? irq : !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt level wrong.");

  property p_tag_seven;
    @(posedge clk) disable iff (rst)
      (lookup.tag == 3'h7 && !wr_high) |=> frame_prio == prio_high_ff[7:6];
  endproperty
  a_tag_seven: assert property (p_tag_seven) else $error("Tag 7 priority wrong.");

  property p_tag_zero;
    @(posedge clk) disable iff (rst)
      (lookup.tag == 3'h0 && !wr_low) |=> frame_prio == prio_low_ff[1:0];
  endproperty
  a_tag_zero: assert property (p_tag_zero) else $error("Tag 0 priority wrong.");

  // Looked at one edge after a reset edge, so the first edge of a run needs no history.
  property p_reset_vals;
    @(posedge clk)
      rst |=> (prio_low_ff == PRIO_LOW_RESET && prio_high_ff == PRIO_HIGH_RESET
        && ind_data == {IND_BYTES{IND_RESET}} && irq_status_ff == 8'h00
        && irq_mask_ff == 8'h00 && rdata == 8'h00 && frame_prio == 2'h0);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("Reset value wrong.");

  // ==========================================================================
  // Further checks: status events, mask hold, holding bytes, map writes and lookups.
  property p_port2_set;
    @(posedge clk) disable iff (rst)
      link_change[2] |=> irq_status_ff[2];
  endproperty
  a_port2_set: assert property (p_port2_set) else $error("Port 2 event not latched.");

  property p_race_port1;
    @(posedge clk) disable iff (rst)
      (link_change[1] && wr_status && req.wdata[1]) |=> irq_status_ff[1];
  endproperty
  a_race_port1: assert property (p_race_port1) else $error("Port 1 lost its event.");

  property p_w1c_port2;
    @(posedge clk) disable iff (rst)
      (wr_status && req.wdata[2] && !link_change[2]) |=> !irq_status_ff[2];
  endproperty
  a_w1c_port2: assert property (p_w1c_port2) else $error("Write one kept port 2.");

  // A status bit may only rise after an event, never from a write or from noise.
  property p_no_spurious;
    @(posedge clk) disable iff (rst)
      (link_change == 2'h0) |=> ((irq_status_ff & ~$past(irq_status_ff)) == 8'h00);
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("Status rose with no event.");

  property p_mask_hold;
    @(posedge clk) disable iff (rst)
      !wr_mask |=> $stable(irq_mask_ff);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("Mask moved without a write.");

  property p_ind_top;
    @(posedge clk) disable iff (rst)
      (req.wr && req.addr == ADDR_IND_BYTE6) |=> ind_data[55:48] == $past(req.wdata);
  endproperty
  a_ind_top: assert property (p_ind_top) else $error("Byte 6 write lost.");

  property p_ind_mid;
    @(posedge clk) disable iff (rst)
      (req.wr && req.addr == ADDR_IND_BYTE4) |=> ind_data[39:32] == $past(req.wdata);
  endproperty
  a_ind_mid: assert property (p_ind_mid) else $error("Byte 4 write lost.");

  property p_ind_low;
    @(posedge clk) disable iff (rst)
      (req.wr && req.addr == ADDR_IND_BYTE0) |=> ind_data[7:0] == $past(req.wdata);
  endproperty
  a_ind_low: assert property (p_ind_low) else $error("Byte 0 write lost.");

  property p_ind_hold;
    @(posedge clk) disable iff (rst)
      !req.wr |=> $stable(ind_data);
  endproperty
  a_ind_hold: assert property (p_ind_hold)
    else $error("Indirect data moved.");

  property p_prio_low_wr;
    @(posedge clk) disable iff (rst)
      wr_low |=> prio_low_ff == $past(req.wdata);
  endproperty
  a_prio_low_wr: assert property (p_prio_low_wr)
    else $error("Low map write lost.");

  property p_prio_high_wr;
    @(posedge clk) disable iff (rst)
      wr_high |=> prio_high_ff == $past(req.wdata);
  endproperty
  a_prio_high_wr: assert property (p_prio_high_wr)
    else $error("High map write lost.");

  property p_tag_three;
    @(posedge clk) disable iff (rst)
      (lookup.tag == 3'h3 && !wr_low) |=> frame_prio == prio_low_ff[7:6];
  endproperty
  a_tag_three: assert property (p_tag_three) else $error("Tag 3 priority wrong.");

endmodule

// ### testbench/sipr_regs_tb.sv
// Self-checking bench for the indirect data, link interrupt and tag priority register slice.
// Assumes read data is registered and settles one cycle after the read strobe edge.
`timescale 1ns/1ps
module testbench;
  import sipr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sipr_req_t req = '0;
  logic [7:0] rdata;
  logic [2:1] link_change = 2'h0;
  sipr_lookup_t lookup = '0;
  logic [1:0] frame_prio;
  logic [55:0] ind_data;
  logic irq;
  int fail_count = 0;
  int checks = 0;
  logic [55:0] exp_ind = '0;
  logic [15:0] map;
  logic [7:0] d;

  // ==========================================================================
  // Clock and device under test
  // The clock toggles every half period of 50 ns for a 10 MHz rate.
  always #50 clk = ~clk;

  sipr_regs uut
  (
    .clk(clk),
    .rst(rst),
    .req(req),
    .rdata(rdata),
    .link_change(link_change),
    .lookup(lookup),
    .frame_prio(frame_prio),
    .ind_data(ind_data),
    .irq(irq)
  );

  // ==========================================================================
  // Access and compare tasks
  // Case inequality is used so that an unknown value never passes as a match.
  task automatic cmp(input logic [55:0] got, input logic [55:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Each task lets a full cycle pass between strobes, so no signal changes twice at once.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    cmp(56'(rdata), 56'(exp));
  endtask

  task automatic pulse(input logic [2:1] p);
    @(negedge clk);
    link_change = p;
    @(negedge clk);
    link_change = 2'h0;
  endtask

  // Raises a link change and a status write at one edge, to test the race between them.
  task automatic race(input logic [2:1] p, input logic [7:0] v);
    @(negedge clk);
    link_change = p;
    req.wr = 1'b1;
    req.addr = ADDR_IRQ_STATUS;
    req.wdata = v;
    @(negedge clk);
    link_change = 2'h0;
    req.wr = 1'b0;
  endtask

  // The priority is registered, so it is looked at one edge after the tag is offered.
  task automatic look(input logic [2:0] t, input logic [1:0] exp);
    @(negedge clk);
    lookup.tag = t;
    @(negedge clk);
    cmp(56'(frame_prio), 56'(exp));
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  // A few hundred cycles suffice for all tests; a hang is cut well after that.
  initial
  begin
    repeat (2000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  // ==========================================================================
  // Test sequence
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int a = 0; a < 7; a++)
      rd(ADDR_IND_BYTE6 + 8'(a), 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h00);
    rd(ADDR_IRQ_MASK, 8'h00);
    rd(ADDR_PRIO_LOW, 8'h50);
    rd(ADDR_PRIO_HIGH, 8'hfa);
    cmp(56'(irq), 56'h0);
    $display("test reset values done");
    // The first byte written ends up in the top bits of the indirect data word.
    for (int a = 0; a < 7; a++)
    begin
      d = 8'h81 + 8'(a) * 8'h11;
      exp_ind = {exp_ind[47:0], d};
      wr(ADDR_IND_BYTE6 + 8'(a), d);
    end
    for (int a = 0; a < 7; a++)
      rd(ADDR_IND_BYTE6 + 8'(a), exp_ind[8 * (6 - a) +: 8]);
    // An offset just past the lowest byte must neither store nor alias into it.
    wr(8'h79, 8'hff);
    rd(8'h79, 8'h00);
    cmp(ind_data, exp_ind);
    $display("test indirect data done");
    pulse(2'b10);
    rd(ADDR_IRQ_STATUS, 8'h04);
    cmp(56'(irq), 56'h1);
    pulse(2'b01);
    rd(ADDR_IRQ_STATUS, 8'h06);
    wr(ADDR_IRQ_STATUS, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h06);
    wr(ADDR_IRQ_MASK, 8'hff);
    rd(ADDR_IRQ_MASK, 8'h06);
    cmp(56'(irq), 56'h0);
    wr(ADDR_IRQ_MASK, 8'h04);
    cmp(56'(irq), 56'h1);
    wr(ADDR_IRQ_STATUS, 8'hfa);
    rd(ADDR_IRQ_STATUS, 8'h04);
    cmp(56'(irq), 56'h0);
    // An event in the very cycle of its clear must survive the clear.
    race(2'b10, 8'h04);
    rd(ADDR_IRQ_STATUS, 8'h04);
    race(2'b01, 8'h02);
    rd(ADDR_IRQ_STATUS, 8'h06);
    cmp(56'(irq), 56'h1);
    wr(ADDR_IRQ_STATUS, 8'h06);
    rd(ADDR_IRQ_STATUS, 8'h00);
    cmp(56'(irq), 56'h0);
    wr(ADDR_IRQ_MASK, 8'h00);
    $display("test link interrupt done");
    map = {PRIO_HIGH_RESET, PRIO_LOW_RESET};
    for (int t = 0; t < 8; t++)
      look(3'(t), map[2 * t +: 2]);
    wr(ADDR_PRIO_LOW, 8'h1b);
    wr(ADDR_PRIO_HIGH, 8'he4);
    map = 16'he41b;
    rd(ADDR_PRIO_LOW, 8'h1b);
    rd(ADDR_PRIO_HIGH, 8'he4);
    for (int t = 0; t < 8; t++)
      look(3'(t), map[2 * t +: 2]);
    $display("test priority map done");
    // A reset in mid-run must bring every register back, whatever was stored.
    pulse(2'b11);
    wr(ADDR_IRQ_MASK, 8'h02);
    cmp(56'(irq), 56'h1);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    cmp(56'(rdata), 56'h0);
    cmp(56'(frame_prio), 56'h0);
    cmp(56'(irq), 56'h0);
    cmp(ind_data, 56'h0);
    rd(ADDR_IRQ_STATUS, 8'h00);
    rd(ADDR_IRQ_MASK, 8'h00);
    rd(ADDR_PRIO_LOW, PRIO_LOW_RESET);
    rd(ADDR_PRIO_HIGH, PRIO_HIGH_RESET);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
